// *** exec_alu.sv ***
// shared constants and types, plus the byte arithmetic unit of the execute core
package exec_pkg;
  // apb byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_INSTR   = 8'h04;
  localparam logic [7:0] OFS_WREG    = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  localparam logic [7:0] OFS_BANK    = 8'h10;
  localparam logic [7:0] OFS_PTR0    = 8'h14;
  localparam logic [7:0] OFS_PTR1    = 8'h18;
  localparam logic [7:0] OFS_PTR2    = 8'h1C;
  localparam logic [7:0] OFS_MEMADDR = 8'h20;
  localparam logic [7:0] OFS_MEMDATA = 8'h24;
  localparam logic [7:0] OFS_WDT     = 8'h28;
  // ctrl field positions
  localparam int CTRL_GO    = 0;
  localparam int CTRL_XINST = 1;
  localparam int CTRL_WAKE  = 2;
  // status field positions
  localparam int ST_C    = 0;
  localparam int ST_DC   = 1;
  localparam int ST_Z    = 2;
  localparam int ST_OV   = 3;
  localparam int ST_N    = 4;
  localparam int ST_PD   = 5;
  localparam int ST_TO   = 6;
  localparam int ST_BUSY = 8;
  localparam int ST_SLP  = 9;
  // instruction word fields
  localparam int BIT_D = 9;
  localparam int BIT_A = 8;
  // opcode patterns
  localparam logic [7:0]  ENC_PTRLD1 = 8'hEE;
  localparam logic [7:0]  ENC_PTRLD2 = 8'hF0;
  localparam logic [5:0]  ENC_MOVE_FILE_REG   = 6'h14;
  localparam logic [5:0]  ENC_SUBWB  = 6'h15;
  localparam logic [15:0] ENC_SLEEP  = 16'h0003;
  // addressing constants
  localparam logic [7:0]  IDX_LIMIT  = 8'h5F;
  localparam logic [7:0]  ACC_SPLIT  = 8'h80;
  localparam logic [3:0]  ACC_HIBANK = 4'hF;
  // reset values and default watchdog limit
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [11:0] RST_PTR    = 12'h000;
  localparam logic [15:0] WDT_LIMIT_DEF = 16'h0FFF;

  typedef enum logic [2:0] {
    OP_NONE  = 3'b000,
    OP_PTRLD = 3'b001,
    OP_MOVE_FILE_REG  = 3'b010,
    OP_SUBWB = 3'b011,
    OP_SLEEP = 3'b100
  } op_e;

  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } flags_s;
endpackage

`timescale 1ns/1ps
module exec_alu (
  // operands
  input  wire logic          [7:0] w_i,
  input  wire logic          [7:0] f_i,
  input  wire exec_pkg::op_e       op_i,
  input  wire exec_pkg::flags_s    flags_i,
  // results
  output logic               [7:0] res_o,
  output exec_pkg::flags_s         flags_o
);
  logic [8:0] diff;
  logic [4:0] ldiff;
  logic       borrow;

  ////////////////////////////////////////////////////////////////////////////
  // move passes f, subtract takes w - f - borrow
  always_comb begin
    borrow  = ~flags_i.c;
    diff    = {1'b0, w_i} - {1'b0, f_i} - {8'h00, borrow};
    ldiff   = {1'b0, w_i[3:0]} - {1'b0, f_i[3:0]} - {4'h0, borrow};
    flags_o = flags_i;
    res_o   = f_i;
    if (op_i == exec_pkg::OP_SUBWB) begin
      res_o      = diff[7:0];
      flags_o.c  = ~diff[8];
      flags_o.dc = ~ldiff[4];
      flags_o.ov = (w_i[7] ^ f_i[7]) & (w_i[7] ^ diff[7]);
      flags_o.n  = diff[7];
      flags_o.z  = (diff[7:0] == 8'h00);
    end else if (op_i == exec_pkg::OP_MOVE_FILE_REG) begin
      flags_o.n = f_i[7];
      flags_o.z = (f_i == 8'h00);
    end
  end
endmodule

// *** exec_core.sv ***
// four-instruction execute core with apb register access and banked data memory
`timescale 1ns/1ps

// How it works
// - Pointer load cycle one takes the top literal nibble from word one and writes it to the pointer high nibble in Q4.
// - Pointer load cycle two takes the low literal byte from word two and writes it to the pointer low byte in Q4.
// - Move-file runs in one cycle: decode Q1, read f Q2, process Q3, write destination Q4.
// - Access bit zero picks the access bank, or pointer two plus a low address up to 0x5F in extended mode; access bit one uses the bank select register.
// - Sleep clears watchdog, clears power-down, sets time-out and halts the core, touching nothing else.
// - A watchdog wake-up from sleep leaves the time-out flag cleared.
// - Subtract-with-borrow computes W minus f minus inverted carry in two's complement.
// - Subtract-with-borrow decodes from top bits 0101 01 with d, a and an 8-bit address below.
// - Subtract-with-borrow updates N, OV, C, Z and DC within its cycle.
module exec_core #(
  parameter int               MEM_AW    = 12,
  parameter logic [15:0]      WDT_LIMIT = exec_pkg::WDT_LIMIT_DEF
) (
  // clock, reset, enable
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  input  wire logic        CE_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // core state
  output logic             BUSY_O,
  output logic             ASLEEP_O
);
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_Q1    = 3'b001,
    S_Q2    = 3'b010,
    S_Q3    = 3'b011,
    S_Q4    = 3'b100,
    S_SLEEP = 3'b101
  } state_e;

  logic                rst_s1_reg, rst_s2_reg;
  state_e              st_reg, st_next;
  exec_pkg::op_e       op_reg, op_next;
  logic                cyc2_reg, cyc2_next;
  logic [31:0]         instr_reg, instr_next;
  logic [7:0]          w_reg, w_next;
  exec_pkg::flags_s    flg_reg, flg_next;
  logic                to_reg, to_next;
  logic                pd_reg, pd_next;
  logic                xinst_reg, xinst_next;
  logic [3:0]          bank_reg, bank_next;
  logic [11:0]         ptr_reg [3];
  logic [11:0]         ptr_next [3];
  logic [MEM_AW-1:0]   ea_reg, ea_next;
  logic [7:0]          opnd_reg, opnd_next;
  logic [7:0]          res_reg, res_next;
  exec_pkg::flags_s    rflg_reg, rflg_next;
  logic [MEM_AW-1:0]   maddr_reg, maddr_next;
  logic [15:0]         wdt_reg, wdt_next;
  logic [31:0]         prdata_next;
  logic                pready_next, pslverr_next;
  logic                mem_we;
  logic [MEM_AW-1:0]   mem_wa;
  logic [7:0]          mem_wd;
  logic [7:0]          mem [2**MEM_AW];
  logic [7:0]          alu_res;
  exec_pkg::flags_s    alu_flg;
  logic                acc, wr_acc, rd_acc, idle;
  logic [1:0]          psel_idx;

  ////////////////////////////////////////////////////////////////////////////
  // decode of an instruction word
  function automatic exec_pkg::op_e decode(input logic [15:0] iw);
    decode = exec_pkg::OP_NONE;
    if (iw[15:8] == exec_pkg::ENC_PTRLD1 && iw[7:6] == 2'b00 && iw[5:4] != 2'b11)
      decode = exec_pkg::OP_PTRLD;
    else if (iw[15:10] == exec_pkg::ENC_MOVE_FILE_REG)
      decode = exec_pkg::OP_MOVE_FILE_REG;
    else if (iw[15:10] == exec_pkg::ENC_SUBWB)
      decode = exec_pkg::OP_SUBWB;
    else if (iw == exec_pkg::ENC_SLEEP)
      decode = exec_pkg::OP_SLEEP;
  endfunction

  // effective data address of a file operand
  function automatic logic [11:0] eff_addr(input logic [15:0] iw, input logic [3:0] bsel,
                                           input logic xi, input logic [11:0] p2);
    if (!iw[exec_pkg::BIT_A] && xi && iw[7:0] <= exec_pkg::IDX_LIMIT)
      eff_addr = p2 + {4'h0, iw[7:0]};
    else if (!iw[exec_pkg::BIT_A])
      eff_addr = (iw[7:0] < exec_pkg::ACC_SPLIT) ? {4'h0, iw[7:0]}
                                                 : {exec_pkg::ACC_HIBANK, iw[7:0]};
    else
      eff_addr = {bsel, iw[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end

  exec_alu u_alu (
    .w_i     (w_reg),
    .f_i     (opnd_reg),
    .op_i    (op_reg),
    .flags_i (flg_reg),
    .res_o   (alu_res),
    .flags_o (alu_flg)
  );

  assign acc      = PSEL_I & PENABLE_I & PREADY_O;
  assign wr_acc   = acc & PWRITE_I;
  assign rd_acc   = PSEL_I & PENABLE_I & ~PREADY_O;
  assign idle     = (st_reg == S_IDLE);
  assign psel_idx = instr_reg[5:4];

  ////////////////////////////////////////////////////////////////////////////
  // next-state: sequencer, registers and bus
  always_comb begin
    st_next      = st_reg;
    op_next      = op_reg;
    cyc2_next    = cyc2_reg;
    instr_next   = instr_reg;
    w_next       = w_reg;
    flg_next     = flg_reg;
    to_next      = to_reg;
    pd_next      = pd_reg;
    xinst_next   = xinst_reg;
    bank_next    = bank_reg;
    ptr_next     = ptr_reg;
    ea_next      = ea_reg;
    opnd_next    = opnd_reg;
    res_next     = res_reg;
    rflg_next    = rflg_reg;
    maddr_next   = maddr_reg;
    wdt_next     = wdt_reg + 16'h0001;
    mem_we       = 1'b0;
    mem_wa       = ea_reg;
    mem_wd       = res_reg;
    prdata_next  = 32'h0000_0000;
    pslverr_next = 1'b0;
    pready_next  = rd_acc;
    // watchdog expiry: wakes from sleep with time-out cleared
    if (wdt_reg >= WDT_LIMIT) begin
      wdt_next = 16'h0000;
      to_next  = 1'b0;
      if (st_reg == S_SLEEP)
        st_next = S_IDLE;
    end
    case (st_reg)
      S_IDLE: begin
      end
      S_Q1: begin
        op_next = cyc2_reg ? exec_pkg::OP_PTRLD : decode(instr_reg[15:0]);
        ea_next = MEM_AW'(eff_addr(instr_reg[15:0], bank_reg, xinst_reg, ptr_reg[2]));
        st_next = S_Q2;
      end
      S_Q2: begin
        opnd_next = cyc2_reg ? instr_reg[23:16]
                             : (op_reg == exec_pkg::OP_PTRLD) ? {4'h0, instr_reg[3:0]}
                             : mem[ea_reg];
        st_next = S_Q3;
      end
      S_Q3: begin
        res_next  = alu_res;
        rflg_next = alu_flg;
        st_next   = S_Q4;
      end
      S_Q4: begin
        st_next = S_IDLE;
        case (op_reg)
          exec_pkg::OP_PTRLD: begin
            if (!cyc2_reg) begin
              ptr_next[psel_idx][11:8] = opnd_reg[3:0];
              cyc2_next = 1'b1;
              st_next   = S_Q1;
            end else begin
              ptr_next[psel_idx][7:0] = opnd_reg;
              cyc2_next = 1'b0;
            end
          end
          exec_pkg::OP_MOVE_FILE_REG, exec_pkg::OP_SUBWB: begin
            flg_next = rflg_reg;
            if (instr_reg[exec_pkg::BIT_D])
              mem_we = 1'b1;
            else
              w_next = res_reg;
          end
          exec_pkg::OP_SLEEP: begin
            wdt_next = 16'h0000;
            pd_next  = 1'b0;
            to_next  = 1'b1;
            st_next  = S_SLEEP;
          end
          default: begin
          end
        endcase
      end
      S_SLEEP: begin
      end
      default: st_next = S_IDLE;
    endcase
    // register reads; writes to unmapped offsets answer without error
    if (rd_acc && !PWRITE_I) begin
      case (PADDR_I)
        exec_pkg::OFS_CTRL:    prdata_next[exec_pkg::CTRL_XINST] = xinst_reg;
        exec_pkg::OFS_INSTR:   prdata_next = instr_reg;
        exec_pkg::OFS_WREG:    prdata_next[7:0] = w_reg;
        exec_pkg::OFS_STATUS:  prdata_next[9:0] = {st_reg == S_SLEEP,
                                                   !idle && st_reg != S_SLEEP, 1'b0,
                                                   to_reg, pd_reg, flg_reg};
        exec_pkg::OFS_BANK:    prdata_next[3:0] = bank_reg;
        exec_pkg::OFS_PTR0:    prdata_next[11:0] = ptr_reg[0];
        exec_pkg::OFS_PTR1:    prdata_next[11:0] = ptr_reg[1];
        exec_pkg::OFS_PTR2:    prdata_next[11:0] = ptr_reg[2];
        exec_pkg::OFS_MEMADDR: prdata_next[MEM_AW-1:0] = maddr_reg;
        exec_pkg::OFS_MEMDATA: prdata_next[7:0] = mem[maddr_reg];
        exec_pkg::OFS_WDT:     prdata_next[15:0] = wdt_reg;
        default:               pslverr_next = 1'b1;
      endcase
    end
    // register writes; all but memory address only while idle, wake also while asleep
    if (wr_acc) begin
      case (PADDR_I)
        exec_pkg::OFS_CTRL: begin
          if (idle) begin
            xinst_next = PWDATA_I[exec_pkg::CTRL_XINST];
            if (PWDATA_I[exec_pkg::CTRL_GO])
              st_next = S_Q1;
          end else if (st_reg == S_SLEEP && PWDATA_I[exec_pkg::CTRL_WAKE])
            st_next = S_IDLE;
        end
        exec_pkg::OFS_INSTR:   if (idle) instr_next = PWDATA_I;
        exec_pkg::OFS_WREG:    if (idle) w_next = PWDATA_I[7:0];
        exec_pkg::OFS_STATUS:  if (idle) flg_next = PWDATA_I[4:0];
        exec_pkg::OFS_BANK:    if (idle) bank_next = PWDATA_I[3:0];
        exec_pkg::OFS_PTR0:    if (idle) ptr_next[0] = PWDATA_I[11:0];
        exec_pkg::OFS_PTR1:    if (idle) ptr_next[1] = PWDATA_I[11:0];
        exec_pkg::OFS_PTR2:    if (idle) ptr_next[2] = PWDATA_I[11:0];
        exec_pkg::OFS_MEMADDR: maddr_next = PWDATA_I[MEM_AW-1:0];
        exec_pkg::OFS_MEMDATA: begin
          if (idle) begin
            mem_we = 1'b1;
            mem_wa = maddr_reg;
            mem_wd = PWDATA_I[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers, frozen while the enable is low
  always_ff @(posedge CLK_I or negedge rst_s2_reg) begin
    if (!rst_s2_reg) begin
      st_reg    <= S_IDLE;
      op_reg    <= exec_pkg::OP_NONE;
      cyc2_reg  <= 1'b0;
      instr_reg <= 32'h0000_0000;
      w_reg     <= exec_pkg::RST_BYTE;
      flg_reg   <= '0;
      to_reg    <= 1'b1;
      pd_reg    <= 1'b1;
      xinst_reg <= 1'b0;
      bank_reg  <= 4'h0;
      ptr_reg   <= '{default: exec_pkg::RST_PTR};
      ea_reg    <= '0;
      opnd_reg  <= exec_pkg::RST_BYTE;
      res_reg   <= exec_pkg::RST_BYTE;
      rflg_reg  <= '0;
      maddr_reg <= '0;
      wdt_reg   <= 16'h0000;
      PRDATA_O  <= 32'h0000_0000;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      BUSY_O    <= 1'b0;
      ASLEEP_O  <= 1'b0;
    end else if (CE_I) begin
      st_reg    <= st_next;
      op_reg    <= op_next;
      cyc2_reg  <= cyc2_next;
      instr_reg <= instr_next;
      w_reg     <= w_next;
      flg_reg   <= flg_next;
      to_reg    <= to_next;
      pd_reg    <= pd_next;
      xinst_reg <= xinst_next;
      bank_reg  <= bank_next;
      ptr_reg   <= ptr_next;
      ea_reg    <= ea_next;
      opnd_reg  <= opnd_next;
      res_reg   <= res_next;
      rflg_reg  <= rflg_next;
      maddr_reg <= maddr_next;
      wdt_reg   <= wdt_next;
      PRDATA_O  <= prdata_next;
      PREADY_O  <= pready_next;
      PSLVERR_O <= pslverr_next;
      BUSY_O    <= (st_next != S_IDLE) && (st_next != S_SLEEP);
      ASLEEP_O  <= (st_next == S_SLEEP);
    end
  end

  // data memory write port, shared by destination writes and software
  always_ff @(posedge CLK_I) begin
    if (CE_I && mem_we)
      mem[mem_wa] <= mem_wd;
  end
endmodule

// *** exec_core_chk.sv ***
// port-level timing checks for the execute core
`timescale 1ns/1ps
module exec_core_chk #(
  parameter int          MEM_AW    = 12,
  parameter logic [15:0] WDT_LIMIT = exec_pkg::WDT_LIMIT_DEF
) (
  // clock, reset, enable
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  input wire logic        CE_I,
  // apb slave
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [7:0]  PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic        PREADY_O,
  input wire logic        PSLVERR_O,
  // core state
  input wire logic        BUSY_O,
  input wire logic        ASLEEP_O
);
  logic        go_wr;
  logic [16:0] slp_cnt_reg;
  logic [16:0] slp_cnt_next;

  default clocking dclk @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);

  // go write accepted on the bus
  assign go_wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && CE_I
                 && PADDR_I == exec_pkg::OFS_CTRL && PWDATA_I[exec_pkg::CTRL_GO];

  // length of the current sleep spell
  always_comb begin
    slp_cnt_next = ASLEEP_O ? slp_cnt_reg + 17'h00001 : 17'h00000;
  end
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      slp_cnt_reg <= 17'h00000;
    end else begin
      slp_cnt_reg <= slp_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  go_start_a: assert property (go_wr && !BUSY_O && !ASLEEP_O |=> BUSY_O)
    else $error("go write did not start execution");
  refuse_go_a: assert property (
    go_wr && ASLEEP_O && !PWDATA_I[exec_pkg::CTRL_WAKE] |=> !BUSY_O)
    else $error("go write started execution while asleep");
  busy_min_a: assert property ($rose(BUSY_O) |-> BUSY_O[*4])
    else $error("execution shorter than four phases");
  busy_max_a: assert property ((BUSY_O && CE_I)[*8] |=> !BUSY_O)
    else $error("execution longer than two cycles");
  sleep_entry_a: assert property ($rose(ASLEEP_O) |-> $past(BUSY_O))
    else $error("sleep entered without an executed instruction");
  sleep_halt_a: assert property (ASLEEP_O |-> !BUSY_O)
    else $error("core executing while asleep");
  wake_bound_a: assert property (slp_cnt_reg <= {1'b0, WDT_LIMIT} + 17'h00004)
    else $error("watchdog did not end sleep");
  ready_pulse_a: assert property (PREADY_O && CE_I |-> (PSEL_I && PENABLE_I) ##1 !PREADY_O)
    else $error("ready outside a one-cycle access answer");
  rdata_idle_a: assert property (!PREADY_O |-> PRDATA_O == 32'h00000000 && !PSLVERR_O)
    else $error("read data or error shown outside an answer");
endmodule

bind exec_core exec_core_chk #(.MEM_AW(MEM_AW), .WDT_LIMIT(WDT_LIMIT)) u_chk (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .BUSY_O(BUSY_O), .ASLEEP_O(ASLEEP_O));

// *** apb_host_model.sv ***
// apb master model running one transfer per request
`timescale 1ns/1ps
module apb_host_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // request side
  input  wire logic        req_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  output logic             done_o,
  output logic      [31:0] rdata_o,
  output logic             err_o,
  // apb master
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic      [7:0]  paddr_o,
  output logic      [31:0] pwdata_o,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i
);
  // setup, access held until ready, then release with scrambled address and data
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {psel_o, penable_o, pwrite_o, done_o, err_o} <= 5'h00;
      paddr_o <= 8'h00;
      pwdata_o <= 32'h0;
      rdata_o <= 32'h0;
    end else begin
      done_o <= 1'b0;
      if (psel_o && penable_o && pready_i) begin
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~paddr_o;
        pwdata_o <= ~pwdata_o;
        rdata_o <= prdata_i;
        err_o <= pslverr_i;
        done_o <= 1'b1;
      end else if (psel_o) begin
        penable_o <= 1'b1;
      end else if (req_i && !done_o) begin
        psel_o <= 1'b1;
        pwrite_o <= wr_i;
        paddr_o <= addr_i;
        pwdata_o <= wdata_i;
      end
    end
  end
endmodule

// *** cpu_instruction_execute_subset_bench.sv ***
// self-checking bench for the execute core
`timescale 1ns/1ps
module cpu_instruction_execute_subset_bench;
  localparam int NC = 6;
  localparam logic [11:0] C_MA [NC] = '{12'h1A5, 12'h020, 12'h110, 12'hF90, 12'h030, 12'h210};
  localparam logic [7:0]  C_FV [NC] = '{8'h03, 8'h02, 8'h01, 8'h80, 8'h01, 8'h42};
  localparam logic [7:0]  C_W  [NC] = '{8'h02, 8'h05, 8'h02, 8'h00, 8'h80, 8'h00};
  localparam logic [4:0]  C_ST [NC] = '{5'h01, 5'h01, 5'h00, 5'h00, 5'h01, 5'h00};
  localparam logic [15:0] C_IN [NC] = '{16'h57A5, 16'h5420, 16'h5510, 16'h5090, 16'h5430, 16'h5010};
  localparam logic [7:0]  C_EW [NC] = '{8'h02, 8'h03, 8'h00, 8'h80, 8'h7F, 8'h42};
  localparam logic [7:0]  C_EF [NC] = '{8'hFF, 8'h02, 8'h01, 8'h80, 8'h01, 8'h42};
  localparam logic [4:0]  C_ES [NC] = '{5'h10, 5'h03, 5'h07, 5'h10, 5'h09, 5'h00};
  localparam logic        C_XI [NC] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic        clk, rst_b, ce, req, wr, done, err, busy, asleep;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  addr, paddr;
  logic [31:0] wdata, rdata, pwdata, prdata;
  int          err_count, n_checks;
  int          busy_cnt = 0;

  exec_core #(.MEM_AW(12), .WDT_LIMIT(16'h0040)) DUT (
    .CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .BUSY_O(busy), .ASLEEP_O(asleep));
  apb_host_model host (
    .clk_i(clk), .rst_b_i(rst_b), .req_i(req), .wr_i(wr), .addr_i(addr), .wdata_i(wdata),
    .done_o(done), .rdata_o(rdata), .err_o(err), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
    .pready_i(pready), .pslverr_i(pslverr));

  // clock and busy cycle tally
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (busy === 1'b1) busy_cnt <= busy_cnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (done !== 1'b1 && n < 100);
    req <= 1'b0;
    if (n >= 100) chk("bus answer", 32'h1, 32'h0);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rdata & m);
  endtask
  task automatic run(input logic [31:0] ins, input logic x, input int cyc);
    int n;
    int c0;
    n = 0;
    c0 = busy_cnt;
    xfer(1'b1, exec_pkg::OFS_INSTR, ins);
    xfer(1'b1, exec_pkg::OFS_CTRL, {30'h0, x, 1'b1});
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'b1 && n < 50);
    chk("busy cycles", 32'(cyc), 32'(busy_cnt - c0));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd_chk("reset status", exec_pkg::OFS_STATUS, 32'hFFFFFFFF, 32'h00000060);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rdata);
    xfer(1'b1, 8'h40, 32'h0);
    chk("unmapped write err", 32'h0, {31'h0, err});
    $display("test reset done");
  endtask
  task automatic t_exec;
    xfer(1'b1, exec_pkg::OFS_BANK, 32'h1);
    xfer(1'b1, exec_pkg::OFS_PTR2, 32'h200);
    for (int i = 0; i < NC; i++) begin
      xfer(1'b1, exec_pkg::OFS_MEMADDR, {20'h0, C_MA[i]});
      xfer(1'b1, exec_pkg::OFS_MEMDATA, {24'h0, C_FV[i]});
      xfer(1'b1, exec_pkg::OFS_WREG, {24'h0, C_W[i]});
      xfer(1'b1, exec_pkg::OFS_STATUS, {27'h0, C_ST[i]});
      run({16'h0, C_IN[i]}, C_XI[i], 4);
      rd_chk("w result", exec_pkg::OFS_WREG, 32'hFF, {24'h0, C_EW[i]});
      rd_chk("f result", exec_pkg::OFS_MEMDATA, 32'hFF, {24'h0, C_EF[i]});
      rd_chk("flags", exec_pkg::OFS_STATUS, 32'h1F, {27'h0, C_ES[i]});
    end
    $display("test exec done");
  endtask
  task automatic t_sleep;
    int n;
    n = 0;
    xfer(1'b1, exec_pkg::OFS_STATUS, 32'h1F);
    run(32'h0003, 1'b0, 4);
    chk("asleep", 32'h1, {31'h0, asleep});
    rd_chk("sleep status", exec_pkg::OFS_STATUS, 32'h3FF, 32'h25F);
    xfer(1'b1, exec_pkg::OFS_CTRL, 32'h1);
    chk("go while asleep", 32'h0, {31'h0, busy});
    xfer(1'b1, exec_pkg::OFS_CTRL, 32'h4);
    rd_chk("wake status", exec_pkg::OFS_STATUS, 32'h3E0, 32'h040);
    run(32'h0003, 1'b0, 4);
    do begin
      @(posedge clk);
      n++;
    end while (asleep === 1'b1 && n < 200);
    rd_chk("watchdog wake status", exec_pkg::OFS_STATUS, 32'h3E0, 32'h000);
    $display("test sleep done");
  endtask
  task automatic t_ptr;
    for (int f = 0; f < 3; f++) begin
      run({8'h00, 8'h5A + 8'(f), 8'hEE, 4'(f), 4'hC}, 1'b0, 8);
      rd_chk("pointer", exec_pkg::OFS_PTR0 + 8'(4 * f), 32'hFFF,
             {20'h0, 4'hC, 8'h5A + 8'(f)});
    end
    $display("test pointer done");
  endtask
  // move-file with the enable dropped for six cycles in mid-execution
  task automatic t_freeze;
    int n;
    int c0;
    n = 0;
    c0 = busy_cnt;
    xfer(1'b1, exec_pkg::OFS_INSTR, 32'h5090);
    xfer(1'b1, exec_pkg::OFS_CTRL, 32'h1);
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (busy === 1'b1 && n < 50);
    chk("frozen busy cycles", 32'h0000000A, 32'(busy_cnt - c0));
    rd_chk("frozen w result", exec_pkg::OFS_WREG, 32'hFF, 32'h80);
    $display("test freeze done");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    {rst_b, req, wr} = 3'h0;
    ce = 1'b1;
    addr = 8'h00;
    wdata = 32'h0;
    {err_count, n_checks} = {32'h0, 32'h0};
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_exec;
    t_sleep;
    t_ptr;
    t_freeze;
    close_out;
  end
  // hang guard, well beyond the few hundred cycles the tests need
  initial begin
    #500000;
    err_count++;
    close_out;
  end
endmodule
